// ==== dv/smc_motion_model.sv ====
/*
 * Motion controller model: drives step and direction terminals.
 * Assumes the caller configures the block before each burst.
 */
`timescale 1ns/100ps
module smc_motion_model (
	input  wire logic mclk,
	output logic      step_line,
	output logic      dir_line
);
	initial begin
		step_line = 1'b0;
		dir_line  = 1'b0;
	end

	// pulses on the terminal the format expects
	task automatic send(input int n, input logic dual, input logic lvl, input logic inact, input logic idle);
		logic on_dir;
		on_dir = dual & lvl;
		@(posedge mclk);
		step_line <= (dual && lvl) ? idle : (dual ? inact : inact);
		dir_line  <= dual ? (lvl ? inact : idle) : lvl;
		// direction set up well before the first edge
		repeat (3) @(posedge mclk);
		for (int i = 0; i < n; i++) begin
			if (on_dir) dir_line <= ~inact; else step_line <= ~inact;
			repeat (2) @(posedge mclk);
			if (on_dir) dir_line <= inact; else step_line <= inact;
			repeat (2) @(posedge mclk);
		end
		repeat (2) @(posedge mclk);
	endtask : send
endmodule : smc_motion_model

// ==== dv/test_smc_stepper_ctrl.sv ====
/*
 * Self-checking bench for the stepper command and fault logic.
 * Assumes the shortened identify window and millisecond count below.
 */
`timescale 1ns/100ps
module test_smc_stepper_ctrl;
	logic mclk = 0, reset_n = 0, sw = 0, idone = 0, fload = 0, cload = 0, fmt = 0, edg = 0, pol = 0;
	logic tstart = 0, tstop = 0, tcyc = 0, trev = 0, wdet = 0, clr_cur = 0, clr_all = 0;
	logic [5:0] ipk = 6'h00, cpk = 6'h1E;
	logic [9:0] cms = 10'h010;
	logic [15:0] cdamp = 16'h0BB8, tint = 16'h0001, trep = 16'h0001, cur = 16'h0000;
	logic [23:0] camp = 24'h000000, cph = 24'h000000;
	logic [7:0] tlen = 8'h01;
	logic [11:0] volt = 12'h000;
	logic step_l, dir_l, mpulse, fwd, astart, abusy, reload, tbusy, fa, fb, fw, prot, anti;
	logic [10:0] ang;
	logic [9:0] res;
	logic [5:0] pk;
	logic [15:0] damp;
	logic [23:0] bamp, bph;
	logic [19:0] hist;
	int num_errors = 0, check_count = 0, n_steps = 0;

	always #20 mclk = ~mclk;
	always @(posedge mclk) if (mpulse === 1'b1) n_steps++;

	smc_motion_model ctrl (.mclk(mclk), .step_line(step_l), .dir_line(dir_l));

	smc_stepper_ctrl #(.ID_WINDOW_CYC(200), .MS_CYC(10)) uut (
		.mclk(mclk), .reset_n(reset_n), .step_pulse_input(step_l), .dir_ccw_input(dir_l),
		.auto_identify_switch(sw), .ident_done(idone), .ident_peak_current(ipk), .factory_load(fload),
		.cfg_load(cload), .command_format_select(fmt), .pulse_edge_select(edg),
		.direction_polarity_setting(pol), .cfg_microstep(cms), .cfg_peak_current(cpk), .cfg_damping(cdamp),
		.cfg_band_amplitude(camp), .cfg_band_phase(cph), .tpg_start(tstart), .tpg_stop(tstop),
		.tpg_cycle(tcyc), .tpg_reverse(trev), .tpg_interval_ms(tint), .tpg_repeat(trep),
		.tpg_length_rev(tlen), .phase_current_ma(cur), .supply_voltage_dv(volt),
		.phase_wiring_detect(wdet), .clear_current(clr_cur), .clear_all(clr_all), .microstep_pulse(mpulse),
		.motor_dir_fwd(fwd), .elec_angle(ang), .microstep_res(res), .peak_current(pk),
		.damping_coefficient(damp), .band_amplitude(bamp), .band_phase(bph), .anti_res_enable(anti),
		.autoid_start(astart), .autoid_busy(abusy), .params_reload(reload), .tpg_busy(tbusy),
		.fault_a_active(fa), .fault_b_active(fb), .phase_wiring_fault(fw), .protection_engage(prot),
		.fault_history(hist));

	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	task automatic cfg(input logic [2:0] sel, input logic [9:0] ms, input logic [5:0] p, input logic [23:0] a);
		@(posedge mclk);
		{fmt, edg, pol} <= sel;
		cms <= ms;
		cpk <= p;
		camp <= a;
		cload <= 1'b1;
		@(posedge mclk);
		cload <= 1'b0;
		tick(1);
	endtask : cfg

	task automatic t_defaults;
		chk("damping", 24'h000BB8, {8'h00, damp});
		chk("band_amp", 24'h800000, bamp);
		chk("band_phase", 24'h800000, bph);
		chk("anti_res", 24'h000001, {23'h0, anti});
	endtask : t_defaults

	task automatic t_steps;
		// dual, falling, polarity, dir level or ccw, idle level
		logic [4:0] tbl [5] = '{5'b00010, 5'b01100, 5'b00110, 5'b10101, 5'b11010};
		logic [4:0] c;
		for (int i = 0; i < 5; i++) begin
			c = tbl[i];
			cfg(c[4:2], 10'h010, 6'h1E, 24'h800000);
			n_steps = 0;
			ctrl.send(3, c[4], c[1], c[3], c[0]);
			chk("step_count", 24'h000003, n_steps[23:0]);
			chk("direction", {23'h0, c[4] ? ~c[1] : c[1] ^ c[2]}, {23'h0, fwd});
		end
		// bursts go +3 +3 -3 +3 -3 microsteps
		chk("elec_angle", 24'h000003, {13'h0, ang});
	endtask : t_steps

	task automatic t_cfg;
		cdamp <= 16'h0064;
		cfg(3'b000, 10'h200, 6'h38, 24'h000000);
		chk("damp_cfg", 24'h000064, {8'h00, damp});
		chk("res_max", 24'h000200, {14'h0, res});
		chk("peak_max", 24'h000038, {18'h0, pk});
		chk("anti_off", 24'h000000, {23'h0, anti});
		cfg(3'b000, 10'h000, 6'h04, 24'h000100);
		chk("res_kept", 24'h000200, {14'h0, res});
		chk("peak_kept", 24'h000038, {18'h0, pk});
		chk("anti_on", 24'h000001, {23'h0, anti});
		@(posedge mclk) fload <= 1'b1;
		@(posedge mclk) fload <= 1'b0;
		tick(1);
		chk("damp_factory", 24'h000BB8, {8'h00, damp});
		chk("amp_factory", 24'h800000, bamp);
		chk("phase_factory", 24'h800000, bph);
	endtask : t_cfg

	task automatic pulse_cond(input int which);
		@(posedge mclk);
		if (which == 0) cur <= 16'h3E81; else if (which == 1) volt <= 12'h38F; else wdet <= 1'b1;
		@(posedge mclk);
		cur <= 16'h0000;
		volt <= 12'h000;
		wdet <= 1'b0;
		tick(2);
	endtask : pulse_cond

	task automatic t_faults;
		@(posedge mclk);
		cur <= 16'h3E80;
		tick(3);
		chk("at_limit", 24'h000000, {23'h0, fa});
		pulse_cond(0);
		chk("over_current", 24'h000001, {23'h0, fa});
		pulse_cond(1);
		chk("over_voltage", 24'h000001, {23'h0, fb & prot});
		chk("history_two", 24'h000006, {4'h0, hist});
		@(posedge mclk) clr_cur <= 1'b1;
		@(posedge mclk) clr_cur <= 1'b0;
		tick(1);
		chk("cleared_flags", 24'h000000, {22'h0, fa, fb});
		chk("history_kept", 24'h000006, {4'h0, hist});
		pulse_cond(2);
		chk("wiring_fault", 24'h000001, {23'h0, fw});
		chk("history_three", 24'h00001B, {4'h0, hist});
		@(posedge mclk) clr_all <= 1'b1;
		@(posedge mclk) clr_all <= 1'b0;
		tick(1);
		chk("all_cleared", 24'h000000, {1'b0, fw, prot, fa, hist});
	endtask : t_faults

	task automatic t_ident;
		@(posedge mclk) sw <= ~sw;
		tick(250);
		@(posedge mclk) sw <= ~sw;
		#1 chk("late_toggle", 24'h000000, {23'h0, astart});
		tick(5);
		@(posedge mclk) sw <= ~sw;
		#1 chk("second_toggle", 24'h000001, {23'h0, astart});
		ipk <= 6'h14;
		@(posedge mclk) idone <= 1'b1;
		#1 chk("id_busy", 24'h000001, {23'h0, abusy});
		@(posedge mclk) idone <= 1'b0;
		#1 chk("id_reload", 24'h000001, {23'h0, reload & abusy});
		tick(3);
		chk("reloaded_peak", 24'h000014, {18'h0, pk});
	endtask : t_ident

	task automatic t_tpg;
		int w;
		cfg(3'b000, 10'h001, 6'h1E, 24'h800000);
		trev <= 1'b1;
		@(posedge mclk) tstart <= 1'b1;
		@(posedge mclk) tstart <= 1'b0;
		for (w = 1; w < 3000 && mpulse !== 1'b1; w++) tick(1);
		chk("first_step", 24'h000001, {23'h0, w > 2490 && w < 2510});
		chk("reverse_dir", 24'h000000, {23'h0, fwd});
		@(posedge mclk) tstop <= 1'b1;
		@(posedge mclk) tstop <= 1'b0;
		tick(2);
		chk("stopped", 24'h000000, {23'h0, tbusy});
	endtask : t_tpg

	task automatic summarize;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize

	initial begin
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		tick(1);
		t_defaults();
		t_steps();
		t_cfg();
		t_faults();
		t_ident();
		t_tpg();
		summarize();
	end

	// about 2900 cycles expected; margin for slow steps
	initial begin
		repeat (30000) @(posedge mclk);
		num_errors++;
		summarize();
	end
endmodule : test_smc_stepper_ctrl

// ==== rtl/smc_edge.sv ====
/*
 * Edge detector for one synchronous level input.
 * Assumes the input is already synchronous to mclk.
 */
`timescale 1ns/100ps
module smc_edge (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic sig,
	output logic      rise,
	output logic      fall
);
	logic prev_q;
	logic prev_d;
	logic armed_q;
	logic armed_d;

	always_comb begin
		prev_d = sig;
		armed_d = 1'b1;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			armed_q <= armed_d;
		end
	end

	// first edge after reset only learns the level, so a high pin gives no false edge
	assign rise = armed_q & sig & ~prev_q;
	assign fall = armed_q & ~sig & prev_q;
endmodule : smc_edge

// ==== rtl/smc_pkg.sv ====
/*
 * Constants shared by the stepper command and fault logic.
 * Assumes a single 25 MHz clock domain.
 */
package smc_pkg;
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned ID_WINDOW_MS   = 1000;
	localparam int unsigned ID_WINDOW_CYC  = CLK_HZ / 1000 * ID_WINDOW_MS;
	localparam int unsigned MS_CYC         = CLK_HZ / 1000;
	localparam int unsigned TPG_STEP_US    = 100;
	localparam int unsigned TPG_STEP_CYC   = CLK_HZ / 1_000_000 * TPG_STEP_US;
	localparam int unsigned HIST_DEPTH     = 10;
	localparam int unsigned NUM_BANDS      = 3;

	localparam logic [9:0]  USTEP_MIN      = 10'h001;
	localparam logic [9:0]  USTEP_MAX      = 10'h200;
	localparam logic [9:0]  USTEP_RST      = 10'h010;
	// peak current in 0.1 A units
	localparam logic [5:0]  PEAK_MIN       = 6'h05;
	localparam logic [5:0]  PEAK_MAX       = 6'h38;
	localparam logic [5:0]  PEAK_RST       = 6'h1E;
	localparam logic [15:0] DAMP_RST       = 16'h0BB8;
	localparam logic [7:0]  BAND1_RST      = 8'h00;
	localparam logic [7:0]  BAND2_RST      = 8'h00;
	localparam logic [7:0]  BAND3_RST      = 8'h80;
	// current in mA, supply in 0.1 V
	localparam logic [15:0] OC_LIMIT_MA    = 16'h3E80;
	localparam logic [11:0] OV_LIMIT_DV    = 12'h38E;
	localparam logic [7:0]  FULL_STEPS_REV = 8'hC8;

	typedef enum logic [1:0] {
		FLT_NONE  = 2'b00,
		FLT_A     = 2'b01,
		FLT_B     = 2'b10,
		FLT_PHASE = 2'b11
	} smc_fault_t;

	typedef enum logic [1:0] {
		ID_IDLE   = 2'b00,
		ID_ARMED  = 2'b01,
		ID_RUN    = 2'b10,
		ID_RELOAD = 2'b11
	} smc_id_state_t;

	typedef enum logic [1:0] {
		TPG_IDLE  = 2'b00,
		TPG_MOVE  = 2'b01,
		TPG_PAUSE = 2'b10
	} smc_tpg_state_t;
endpackage : smc_pkg

// ==== rtl/smc_stepper_ctrl.sv ====
/*
 * Stepper command decode, configuration hold, auto-identify trigger,
 * test pulse merge and fault supervision.
 * Assumes all inputs synchronous to mclk; measurements come from an ADC stage.
 */
// Summary of operation
// (R1) two switch toggles in 1 s start identify
// (R2) microstep resolution 1 to 512, scales steps
// (R3) peak current 0.5 to 5.6 A held
// (R4) pulse-direction or dual-pulse command format
// (R5) step counted on selected edge only
// (R6) dual-pulse ignores idle terminal level
// (R7) direction polarity picks high or low forward
// (R8) polarity used only in pulse-direction mode
// (R9) damping coefficient defaults to 3000
// (R10) anti-resonance off when all corrections zero
// (R11) three bands, band two defaults zero
// (R12) band three defaults to 128
// (R13) cycle option repeats test motion
// (R14) reverse option flips test direction
// (R15) millisecond pause between test cycles
// (R16) stop after repeat count of revolutions
// (R17) ten-entry fault history, newest at zero
// (R18) clear-current clears active flags only
// (R19) clear-all clears flags and history
// (R20) over 16 A raises current fault
// (R21) above 91 V raises voltage fault
// (R22) miswired phase raises wiring fault
// (R23) test length converted via microsteps
`timescale 1ns/100ps
module smc_stepper_ctrl #(
	parameter int unsigned ID_WINDOW_CYC = smc_pkg::ID_WINDOW_CYC,
	parameter int unsigned MS_CYC        = smc_pkg::MS_CYC
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        step_pulse_input,
	input  wire logic        dir_ccw_input,
	input  wire logic        auto_identify_switch,
	input  wire logic        ident_done,
	input  wire logic [5:0]  ident_peak_current,
	input  wire logic        factory_load,
	input  wire logic        cfg_load,
	input  wire logic        command_format_select,
	input  wire logic        pulse_edge_select,
	input  wire logic        direction_polarity_setting,
	input  wire logic [9:0]  cfg_microstep,
	input  wire logic [5:0]  cfg_peak_current,
	input  wire logic [15:0] cfg_damping,
	input  wire logic [23:0] cfg_band_amplitude,
	input  wire logic [23:0] cfg_band_phase,
	input  wire logic        tpg_start,
	input  wire logic        tpg_stop,
	input  wire logic        tpg_cycle,
	input  wire logic        tpg_reverse,
	input  wire logic [15:0] tpg_interval_ms,
	input  wire logic [15:0] tpg_repeat,
	input  wire logic [7:0]  tpg_length_rev,
	input  wire logic [15:0] phase_current_ma,
	input  wire logic [11:0] supply_voltage_dv,
	input  wire logic        phase_wiring_detect,
	input  wire logic        clear_current,
	input  wire logic        clear_all,
	output logic             microstep_pulse,
	output logic             motor_dir_fwd,
	output logic [10:0]      elec_angle,
	output logic [9:0]       microstep_res,
	output logic [5:0]       peak_current,
	output logic [15:0]      damping_coefficient,
	output logic [23:0]      band_amplitude,
	output logic [23:0]      band_phase,
	output logic             anti_res_enable,
	output logic             autoid_start,
	output logic             autoid_busy,
	output logic             params_reload,
	output logic             tpg_busy,
	output logic             fault_a_active,
	output logic             fault_b_active,
	output logic             phase_wiring_fault,
	output logic             protection_engage,
	output logic [19:0]      fault_history
);
	// configuration
	logic                                fmt_q, fmt_d;
	logic                                edge_q, edge_d;
	logic                                pol_q, pol_d;
	logic [9:0]                          ustep_q, ustep_d;
	logic [5:0]                          peak_q, peak_d;
	logic [15:0]                         damp_q, damp_d;
	logic [smc_pkg::NUM_BANDS-1:0][7:0] amp_q, amp_d;
	logic [smc_pkg::NUM_BANDS-1:0][7:0] ph_q, ph_d;
	// identify sequencer
	smc_pkg::smc_id_state_t              id_q, id_d;
	logic [24:0]                         win_q, win_d;
	// motion
	logic                                mpulse_q, mpulse_d;
	logic                                mfwd_q, mfwd_d;
	logic [10:0]                         ang_q, ang_d;
	// faults
	logic [2:0]                          act_q, act_d;
	logic [smc_pkg::HIST_DEPTH-1:0][1:0] hist_q, hist_d;

	logic        st_rise, st_fall, cc_rise, cc_fall, sw_rise, sw_fall;
	logic        st_edge, cc_edge, sw_toggle;
	logic        tpg_step, tpg_rev;
	logic        mv_step, mv_fwd;
	logic [2:0]  cond, newf;
	logic [10:0] ang_top;
	smc_pkg::smc_fault_t new_code;

	smc_edge u_step_edge (
		.mclk    (mclk),
		.reset_n (reset_n),
		.sig     (step_pulse_input),
		.rise    (st_rise),
		.fall    (st_fall)
	);
	smc_edge u_ccw_edge (
		.mclk    (mclk),
		.reset_n (reset_n),
		.sig     (dir_ccw_input),
		.rise    (cc_rise),
		.fall    (cc_fall)
	);
	smc_edge u_sw_edge (
		.mclk    (mclk),
		.reset_n (reset_n),
		.sig     (auto_identify_switch),
		.rise    (sw_rise),
		.fall    (sw_fall)
	);

	smc_test_pulser #(
		.MS_CYC (MS_CYC)
	) u_tpg (
		.mclk         (mclk),
		.reset_n      (reset_n),
		.start        (tpg_start),
		.stop         (tpg_stop),
		.cycle_en     (tpg_cycle),
		.reverse      (tpg_reverse),
		.interval_ms  (tpg_interval_ms),
		.repeat_count (tpg_repeat),
		.length_rev   (tpg_length_rev),
		.ustep_res    (ustep_q),
		.step         (tpg_step),
		.dir_rev      (tpg_rev),
		.busy         (tpg_busy)
	);

	// (R5) selected active edge
	assign st_edge = edge_q ? st_fall : st_rise;
	assign cc_edge = edge_q ? cc_fall : cc_rise;
	assign sw_toggle = sw_rise | sw_fall;

	// configuration hold; factory load wins over reload and writes
	always_comb begin
		fmt_d = fmt_q;
		edge_d = edge_q;
		pol_d = pol_q;
		ustep_d = ustep_q;
		peak_d = peak_q;
		damp_d = damp_q;
		amp_d = amp_q;
		ph_d = ph_q;
		if (factory_load) begin
			ustep_d = smc_pkg::USTEP_RST;
			peak_d = smc_pkg::PEAK_RST;
			// (R9) (R11) (R12) factory defaults
			damp_d = smc_pkg::DAMP_RST;
			amp_d = {smc_pkg::BAND3_RST, smc_pkg::BAND2_RST, smc_pkg::BAND1_RST};
			ph_d = {smc_pkg::BAND3_RST, smc_pkg::BAND2_RST, smc_pkg::BAND1_RST};
		end else if (id_q == smc_pkg::ID_RELOAD) begin
			// (R1) reload identified peak current
			if (ident_peak_current >= smc_pkg::PEAK_MIN && ident_peak_current <= smc_pkg::PEAK_MAX) begin
				peak_d = ident_peak_current;
			end
		end else if (cfg_load) begin
			fmt_d = command_format_select;
			edge_d = pulse_edge_select;
			pol_d = direction_polarity_setting;
			// (R2) out-of-range resolution ignored
			if (cfg_microstep >= smc_pkg::USTEP_MIN && cfg_microstep <= smc_pkg::USTEP_MAX) begin
				ustep_d = cfg_microstep;
			end
			// (R3) out-of-range current ignored
			if (cfg_peak_current >= smc_pkg::PEAK_MIN && cfg_peak_current <= smc_pkg::PEAK_MAX) begin
				peak_d = cfg_peak_current;
			end
			damp_d = cfg_damping;
			amp_d = cfg_band_amplitude;
			ph_d = cfg_band_phase;
		end
	end

	// identify sequencer; window counter only runs while armed
	always_comb begin
		id_d = id_q;
		win_d = win_q + 25'h0000001;
		unique case (id_q)
			smc_pkg::ID_IDLE: begin
				win_d = 25'h0000000;
				if (sw_toggle) begin
					id_d = smc_pkg::ID_ARMED;
				end
			end
			smc_pkg::ID_ARMED: begin
				// (R1) second toggle inside window
				if (sw_toggle) begin
					id_d = smc_pkg::ID_RUN;
				end else if (win_q == 25'(ID_WINDOW_CYC - 1)) begin
					id_d = smc_pkg::ID_IDLE;
				end
			end
			smc_pkg::ID_RUN: begin
				win_d = 25'h0000000;
				if (ident_done) begin
					id_d = smc_pkg::ID_RELOAD;
				end
			end
			smc_pkg::ID_RELOAD: begin
				win_d = 25'h0000000;
				id_d = smc_pkg::ID_IDLE;
			end
		endcase
	end

	assign autoid_start = id_q == smc_pkg::ID_ARMED && sw_toggle;
	assign autoid_busy = id_q == smc_pkg::ID_RUN || id_q == smc_pkg::ID_RELOAD;
	assign params_reload = id_q == smc_pkg::ID_RELOAD;

	// motion source; test generator owns the motor while busy
	always_comb begin
		mv_step = 1'b0;
		mv_fwd = mfwd_q;
		// last generated step lands after busy drops; keep it
		if (tpg_busy || tpg_step) begin
			mv_step = tpg_step;
			// (R14) reverse test direction
			mv_fwd = ~tpg_rev;
		end else if (fmt_q) begin
			// (R4) (R6) dual-pulse, edges only; coincident edges cancel
			mv_step = st_edge ^ cc_edge;
			mv_fwd = st_edge;
		end else begin
			// (R4) (R7) (R8) pulse with direction
			mv_step = st_edge;
			mv_fwd = pol_q ? ~dir_ccw_input : dir_ccw_input;
		end
	end

	// (R2) electrical period is four full steps of ustep microsteps
	assign ang_top = 11'({ustep_q, 2'b00} - 12'h001);

	always_comb begin
		mpulse_d = mv_step;
		mfwd_d = mv_step ? mv_fwd : mfwd_q;
		ang_d = ang_q;
		if (ang_q > ang_top) begin
			ang_d = 11'h000;
		end else if (mv_step) begin
			if (mv_fwd) begin
				ang_d = ang_q == ang_top ? 11'h000 : ang_q + 11'h001;
			end else begin
				ang_d = ang_q == 11'h000 ? ang_top : ang_q - 11'h001;
			end
		end
	end

	// (R20) (R21) (R22) fault conditions
	assign cond = {phase_wiring_detect, supply_voltage_dv > smc_pkg::OV_LIMIT_DV,
		phase_current_ma > smc_pkg::OC_LIMIT_MA};
	assign newf = cond & ~act_q;

	always_comb begin
		if (newf[0]) begin
			new_code = smc_pkg::FLT_A;
		end else if (newf[1]) begin
			new_code = smc_pkg::FLT_B;
		end else begin
			new_code = smc_pkg::FLT_PHASE;
		end
	end

	always_comb begin
		act_d = act_q;
		hist_d = hist_q;
		// (R18) (R19) clear active flags
		if (clear_current || clear_all) begin
			act_d = 3'h0;
		end
		// (R19) wipe history
		if (clear_all) begin
			hist_d = '0;
		end
		// setting beats a same-cycle clear
		act_d = act_d | cond;
		// (R17) newest at entry zero
		if (|newf) begin
			hist_d = {hist_d[smc_pkg::HIST_DEPTH-2:0], new_code};
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			fmt_q <= 1'b0;
			edge_q <= 1'b0;
			pol_q <= 1'b0;
			ustep_q <= smc_pkg::USTEP_RST;
			peak_q <= smc_pkg::PEAK_RST;
			damp_q <= smc_pkg::DAMP_RST;
			amp_q <= {smc_pkg::BAND3_RST, smc_pkg::BAND2_RST, smc_pkg::BAND1_RST};
			ph_q <= {smc_pkg::BAND3_RST, smc_pkg::BAND2_RST, smc_pkg::BAND1_RST};
			id_q <= smc_pkg::ID_IDLE;
			win_q <= 25'h0000000;
			mpulse_q <= 1'b0;
			mfwd_q <= 1'b1;
			ang_q <= 11'h000;
			act_q <= 3'h0;
			hist_q <= '0;
		end else begin
			fmt_q <= fmt_d;
			edge_q <= edge_d;
			pol_q <= pol_d;
			ustep_q <= ustep_d;
			peak_q <= peak_d;
			damp_q <= damp_d;
			amp_q <= amp_d;
			ph_q <= ph_d;
			id_q <= id_d;
			win_q <= win_d;
			mpulse_q <= mpulse_d;
			mfwd_q <= mfwd_d;
			ang_q <= ang_d;
			act_q <= act_d;
			hist_q <= hist_d;
		end
	end

	assign microstep_pulse = mpulse_q;
	assign motor_dir_fwd = mfwd_q;
	assign elec_angle = ang_q;
	assign microstep_res = ustep_q;
	assign peak_current = peak_q;
	assign damping_coefficient = damp_q;
	assign band_amplitude = amp_q;
	assign band_phase = ph_q;
	// (R10) enable when any correction nonzero
	assign anti_res_enable = |{amp_q, ph_q};
	assign fault_a_active = act_q[0];
	assign fault_b_active = act_q[1];
	assign phase_wiring_fault = act_q[2];
	assign protection_engage = |act_q;
	assign fault_history = hist_q;

	a_ustep_range: assert property (@(posedge mclk) disable iff (!reset_n) // (R2)
		cfg_load && !factory_load && id_q != smc_pkg::ID_RELOAD && cfg_microstep == 10'h000
		|=> ustep_q == $past(ustep_q))
		else $error("zero resolution accepted");
	a_peak_range: assert property (@(posedge mclk) disable iff (!reset_n) // (R3)
		peak_q >= smc_pkg::PEAK_MIN && peak_q <= smc_pkg::PEAK_MAX)
		else $error("peak current out of range");
	a_factory_vals: assert property (@(posedge mclk) disable iff (!reset_n) // (R9)
		factory_load |=> damp_q == 16'h0BB8 && amp_q[1] == 8'h00 && ph_q[2] == 8'h80)
		else $error("factory defaults wrong");
	a_antires_off: assert property (@(posedge mclk) disable iff (!reset_n) // (R10)
		cfg_load && !factory_load && id_q != smc_pkg::ID_RELOAD
		&& cfg_band_amplitude == 24'h000000 && cfg_band_phase == 24'h000000 |=> !anti_res_enable)
		else $error("anti-resonance not disabled");
	a_edge_step: assert property (@(posedge mclk) disable iff (!reset_n) // (R5)
		!tpg_busy && !tpg_step && !fmt_q && !edge_q && $rose(step_pulse_input) |=> microstep_pulse)
		else $error("rising edge not stepped");
	a_dir_pol: assert property (@(posedge mclk) disable iff (!reset_n) // (R7)
		!tpg_busy && !tpg_step && !fmt_q && st_edge |=> motor_dir_fwd == (pol_q ^ $past(dir_ccw_input)))
		else $error("direction polarity wrong");
	a_id_window: assert property (@(posedge mclk) disable iff (!reset_n) // (R1)
		autoid_start |=> id_q == smc_pkg::ID_RUN)
		else $error("identify not started");
	a_oc_fault: assert property (@(posedge mclk) disable iff (!reset_n) // (R20)
		phase_current_ma > 16'h3E80 |=> fault_a_active && protection_engage)
		else $error("over-current missed");
	a_ov_fault: assert property (@(posedge mclk) disable iff (!reset_n) // (R21)
		supply_voltage_dv > 12'h38E |=> fault_b_active)
		else $error("over-voltage missed");
	a_hist_shift: assert property (@(posedge mclk) disable iff (!reset_n) // (R17)
		|newf && !clear_all |=> fault_history[3:2] == $past(fault_history[1:0]))
		else $error("history did not shift");
	a_clear_cur: assert property (@(posedge mclk) disable iff (!reset_n) // (R18)
		clear_current && !clear_all && cond == 3'h0 |=> act_q == 3'h0 && $stable(hist_q))
		else $error("clear-current wrong");
	a_clear_all: assert property (@(posedge mclk) disable iff (!reset_n) // (R19)
		clear_all && cond == 3'h0 |=> hist_q == '0 && act_q == 3'h0)
		else $error("clear-all wrong");
	c_autoid: cover property (@(posedge mclk) disable iff (!reset_n) autoid_start);
	c_dual_ccw: cover property (@(posedge mclk) disable iff (!reset_n) fmt_q && cc_edge && !st_edge);
	c_hist_full: cover property (@(posedge mclk) disable iff (!reset_n) hist_q[9] != 2'b00);
endmodule : smc_stepper_ctrl

// ==== rtl/smc_test_pulser.sv ====
/*
 * Internal test pulse generator: moves a set number of revolutions,
 * pauses, and repeats. Assumes settings stay stable while busy.
 */
`timescale 1ns/100ps
module smc_test_pulser #(
	parameter int unsigned MS_CYC = smc_pkg::MS_CYC
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic        stop,
	input  wire logic        cycle_en,
	input  wire logic        reverse,
	input  wire logic [15:0] interval_ms,
	input  wire logic [15:0] repeat_count,
	input  wire logic [7:0]  length_rev,
	input  wire logic [9:0]  ustep_res,
	output logic             step,
	output logic             dir_rev,
	output logic             busy
);
	smc_pkg::smc_tpg_state_t st_q, st_d;
	logic [25:0] target;
	logic [25:0] step_cnt_q, step_cnt_d;
	logic [11:0] div_q, div_d;
	logic [15:0] ms_cnt_q, ms_cnt_d;
	logic [15:0] ms_left_q, ms_left_d;
	logic [15:0] done_q, done_d;
	logic        step_q, step_d;

	// (R23) revolutions to microsteps
	assign target = 26'(length_rev) * 26'(ustep_res) * 26'(smc_pkg::FULL_STEPS_REV);

	always_comb begin
		st_d = st_q;
		step_cnt_d = step_cnt_q;
		div_d = div_q;
		ms_cnt_d = ms_cnt_q;
		ms_left_d = ms_left_q;
		done_d = done_q;
		step_d = 1'b0;
		unique case (st_q)
			smc_pkg::TPG_IDLE: begin
				if (start && target != 26'h0000000) begin
					st_d = smc_pkg::TPG_MOVE;
					step_cnt_d = 26'h0000000;
					div_d = 12'h000;
					done_d = 16'h0000;
				end
			end
			smc_pkg::TPG_MOVE: begin
				div_d = div_q + 12'h001;
				if (div_q == 12'(smc_pkg::TPG_STEP_CYC - 1)) begin
					div_d = 12'h000;
					step_d = 1'b1;
					step_cnt_d = step_cnt_q + 26'h0000001;
					if (step_cnt_q == target - 26'h0000001) begin
						step_cnt_d = 26'h0000000;
						done_d = done_q + 16'h0001;
						// (R13) (R16) repeat or stop
						if (!cycle_en || done_q + 16'h0001 >= repeat_count) begin
							st_d = smc_pkg::TPG_IDLE;
						end else begin
							// (R15) pause between cycles
							st_d = smc_pkg::TPG_PAUSE;
							ms_left_d = interval_ms;
							ms_cnt_d = 16'h0000;
						end
					end
				end
			end
			smc_pkg::TPG_PAUSE: begin
				ms_cnt_d = ms_cnt_q + 16'h0001;
				if (ms_left_q == 16'h0000) begin
					st_d = smc_pkg::TPG_MOVE;
				end else if (ms_cnt_q == 16'(MS_CYC - 1)) begin
					ms_cnt_d = 16'h0000;
					ms_left_d = ms_left_q - 16'h0001;
				end
			end
			default: begin
				st_d = smc_pkg::TPG_IDLE;
			end
		endcase
		if (stop) begin
			st_d = smc_pkg::TPG_IDLE;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= smc_pkg::TPG_IDLE;
			step_cnt_q <= 26'h0000000;
			div_q <= 12'h000;
			ms_cnt_q <= 16'h0000;
			ms_left_q <= 16'h0000;
			done_q <= 16'h0000;
			step_q <= 1'b0;
		end else begin
			st_q <= st_d;
			step_cnt_q <= step_cnt_d;
			div_q <= div_d;
			ms_cnt_q <= ms_cnt_d;
			ms_left_q <= ms_left_d;
			done_q <= done_d;
			step_q <= step_d;
		end
	end

	assign step = step_q;
	// (R14) reverse option
	assign dir_rev = reverse;
	assign busy = st_q != smc_pkg::TPG_IDLE;

	a_pause_len: assert property (@(posedge mclk) disable iff (!reset_n) // (R15)
		st_q == smc_pkg::TPG_PAUSE && ms_left_q != 16'h0000 && !stop |=> st_q == smc_pkg::TPG_PAUSE)
		else $error("pause ended early");
	a_stop_idle: assert property (@(posedge mclk) disable iff (!reset_n) // (R16)
		stop |=> !busy)
		else $error("generator ignored stop");
	c_tpg_pause: cover property (@(posedge mclk) disable iff (!reset_n)
		st_q == smc_pkg::TPG_PAUSE ##1 st_q == smc_pkg::TPG_MOVE);
endmodule : smc_test_pulser
